/* design/dam_pkg.sv */
// Shared constants and types for the dual converter output mux and power control.
package dam_pkg;

  // Clock period of the control logic.
  localparam int unsigned CLK_PERIOD_NS = 10;

  // Wake-up times, in their own unit, and derived cycle counts (least times round up).
  localparam int unsigned SHDN_WAKE_NS  = 20000;
  localparam int unsigned STBY_WAKE_NS  = 5500;
  localparam int unsigned DRV_WAKE_NS   = 5;
  localparam int unsigned SHDN_WAKE_CYC = (SHDN_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned STBY_WAKE_CYC = (STBY_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DRV_WAKE_CYC  = (DRV_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Conversion geometry.
  localparam int unsigned SAMPLE_W      = 8;
  localparam int unsigned PIPE_STAGES   = 7;
  localparam int unsigned LAT_A_HALF    = 10;
  localparam int unsigned LAT_B_HALF    = 11;
  localparam logic [7:0]  CODE_OFFSET   = 8'h80;
  localparam logic [7:0]  BUS_RESET     = 8'h80;

  // Wake counter width.
  localparam int unsigned WAKE_CNT_W    = 16;

  // Power modes, coded as {power_select_low, power_select_high}.
  typedef enum logic [1:0] {
    DAM_SHUTDOWN = 2'b00,
    DAM_STANDBY  = 2'b01,
    DAM_IDLE     = 2'b10,
    DAM_NORMAL   = 2'b11
  } dam_mode_e;

  // Reference operating modes.
  typedef enum logic [1:0] {
    DAM_REF_INTERNAL = 2'b00,
    DAM_REF_BUFFERED = 2'b01,
    DAM_REF_UNBUF    = 2'b10
  } dam_ref_e;

endpackage

/* design/dam_pwr_if.sv */
// Power status carried from the power sequencer to the conversion datapath.
`timescale 1ns/100ps
interface dam_pwr_if;
  import dam_pkg::*;
  logic ref_en;
  logic adc_en;
  logic clk_on;
  logic adc_on;
  logic drive_on;

  modport ctl (output ref_en, output adc_en, output clk_on, output adc_on, output drive_on);
  modport use_p (input ref_en, input adc_en, input clk_on, input adc_on, input drive_on);
endinterface

/* design/dam_power.sv */
// Power-mode sequencer: wake-up timing for reference, converters and output drivers.
`timescale 1ns/100ps
module dam_power
  import dam_pkg::*;
#(
  parameter int unsigned UNBUF_WAKE_CYC = SHDN_WAKE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  // Decoded controls
  input  wire dam_mode_e mode,
  input  wire logic      ref_unbuf,
  // Status out
  dam_pwr_if.ctl         pwr
);

  // Refuse a wake count that the counter cannot reach.
  if (UNBUF_WAKE_CYC < 1 || UNBUF_WAKE_CYC >= (1 << WAKE_CNT_W)) begin : g_bad_wake
    $error("dam_power: UNBUF_WAKE_CYC out of range");
  end

  logic                  ref_ok_r;
  logic                  adc_ok_r;
  logic                  drive_r;
  logic [WAKE_CNT_W-1:0] ref_cnt_r;
  logic [WAKE_CNT_W-1:0] adc_cnt_r;

  // RULE9 shutdown powers off
  wire ref_want = (mode != DAM_SHUTDOWN);
  // RULE11 standby keeps converters off
  wire adc_want = ref_ok_r && (mode == DAM_IDLE || mode == DAM_NORMAL);
  // RULE10 shutdown wake time
  wire [WAKE_CNT_W-1:0] ref_target = ref_unbuf ? WAKE_CNT_W'(UNBUF_WAKE_CYC - 1)
                                               : WAKE_CNT_W'(SHDN_WAKE_CYC - 1);
  wire ref_done = (ref_cnt_r == ref_target);
  // RULE11 standby wake time
  wire adc_done = (adc_cnt_r == WAKE_CNT_W'(STBY_WAKE_CYC - 1));
  // RULE12 driver start delay
  wire drive_nxt = adc_ok_r && (mode == DAM_NORMAL);

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_ok_r  <= 1'b0;
      ref_cnt_r <= '0;
    end else if (ce) begin
      if (!ref_want) begin
        ref_ok_r  <= 1'b0;
        ref_cnt_r <= '0;
      end else if (!ref_ok_r) begin
        ref_ok_r  <= ref_done;
        ref_cnt_r <= ref_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      adc_ok_r  <= 1'b0;
      adc_cnt_r <= '0;
    end else if (ce) begin
      if (!adc_want) begin
        adc_ok_r  <= 1'b0;
        adc_cnt_r <= '0;
      end else if (!adc_ok_r) begin
        adc_ok_r  <= adc_done;
        adc_cnt_r <= adc_cnt_r + 1'b1;
      end
    end
  end

  // The driver delay is one cycle at this clock rate, so a single register serves.
  always_ff @(posedge clk) begin
    if (rst) begin
      drive_r <= 1'b0;
    end else if (ce) begin
      drive_r <= drive_nxt;
    end
  end

  assign pwr.ref_en   = ref_want;
  assign pwr.adc_en   = adc_want;
  assign pwr.clk_on   = ref_ok_r;
  assign pwr.adc_on   = adc_ok_r;
  assign pwr.drive_on = drive_r;

endmodule

/* design/dam_top.sv */
// Dual-channel converter datapath: sampling, half-cycle pipeline, output mux and pin drive.
`timescale 1ns/100ps

// Overview of operation
// RULE1: each sample walks seven pipeline stages, one stage per half clock period.
// RULE2: first channel appears after 5 cycles, second channel after 5.5 cycles.
// RULE3: both channels are sampled together on each converter clock rising edge.
// RULE4: bus gets first channel on rising edges, second channel on falling edges.
// RULE5: channel flag follows the clock; high for first channel, low for second.
// RULE6: results are offset binary: signed input plus 128, zero gives 0x80.
// RULE7: +127 gives 255, -128 gives 0; +126, +1, -1 give 254, 129, 127.
// RULE8: power selects decode to shutdown, standby, idle or normal operation.
// RULE9: shutdown turns off converters, reference, clock distribution and tri-states outputs.
// RULE10: leaving shutdown takes about 20 us, unbuffered reference depends on drivers.
// RULE11: standby keeps reference and clocks, unpowers converters, wake takes 5.5 us.
// RULE12: idle runs everything but tri-states outputs; drivers start about 5 ns later.
// RULE13: when outputs become driven, the latest converted word is on the bus.
// RULE14: normal operation powers all sections and drives bus and channel flag.
// RULE15: reference level selects internal, buffered external or unbuffered external reference.
// RULE16: unbuffered reference mode disables the on-chip reference node buffers.
// RULE17: the clock source supplies a 50 percent plus or minus 10 percent duty cycle.
// RULE18: output latch holds its word while tri-stated so it reappears on enable; the code holds it only while stopped and keeps loading it in idle.
// RULE19: bus has eight lines, most significant bit on top, least on bottom.
module dam_top
  import dam_pkg::*;
#(
  parameter int unsigned UNBUF_WAKE_CYC = SHDN_WAKE_CYC,
  parameter int unsigned LAT_A          = LAT_A_HALF,
  parameter int unsigned LAT_B          = LAT_B_HALF
) (
  // System clock, reset and enable
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                ce,
  // Converter clock pin
  input  wire logic                conv_clk,
  // Held channel results, signed two's complement in LSB
  input  wire logic [SAMPLE_W-1:0] first_channel,
  input  wire logic [SAMPLE_W-1:0] second_channel,
  // Power select pins
  input  wire logic                power_select_low,
  input  wire logic                power_select_high,
  // Reference level comparator outputs
  input  wire logic                ref_level_high,
  input  wire logic                ref_level_low,
  // Shared output bus and channel flag
  output logic [SAMPLE_W-1:0]      sample_bus,
  output logic                     sample_bus_oe,
  output logic                     channel_flag,
  output logic                     channel_flag_oe,
  // Analog section controls
  output logic                     adc_power_en,
  output logic                     reference_power_en,
  output logic                     clock_dist_en,
  output logic                     ref_buffer_en,
  output logic [1:0]               reference_mode,
  output logic                     converter_ready
);

  // Refuse latencies that the two output taps cannot serve.
  if (LAT_A < 2 || LAT_B != LAT_A + 1) begin : g_bad_lat
    $error("dam_top: latencies must satisfy LAT_A >= 2 and LAT_B = LAT_A + 1");
  end
  if (LAT_B < PIPE_STAGES) begin : g_short_lat
    $error("dam_top: latency shorter than the pipeline");
  end

  localparam int unsigned DEPTH = LAT_B;

  // Input synchronisers. Stage one feeds stage two only.
  logic                cclk_s1_r;
  logic                cclk_s2_r;
  logic                cclk_s3_r;
  logic [SAMPLE_W-1:0] cha_s1_r;
  logic [SAMPLE_W-1:0] cha_s2_r;
  logic [SAMPLE_W-1:0] chb_s1_r;
  logic [SAMPLE_W-1:0] chb_s2_r;
  logic [1:0]          psel_s1_r;
  logic [1:0]          psel_s2_r;
  logic [1:0]          rlev_s1_r;
  logic [1:0]          rlev_s2_r;

  // Converter clock pin: two stages, then one edge-detect delay.
  always_ff @(posedge clk) begin
    if (rst) begin
      cclk_s1_r <= 1'b0;
    end else if (ce) begin
      cclk_s1_r <= conv_clk;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cclk_s2_r <= 1'b0;
    end else if (ce) begin
      cclk_s2_r <= cclk_s1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cclk_s3_r <= 1'b0;
    end else if (ce) begin
      cclk_s3_r <= cclk_s2_r;
    end
  end

  // Channel words are synchronised bit by bit. A word that changes near the
  // sampling edge can be caught half old, half new, so the source must hold it.
  always_ff @(posedge clk) begin
    if (rst) begin
      cha_s1_r <= '0;
    end else if (ce) begin
      cha_s1_r <= first_channel;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cha_s2_r <= '0;
    end else if (ce) begin
      cha_s2_r <= cha_s1_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chb_s1_r <= '0;
    end else if (ce) begin
      chb_s1_r <= second_channel;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      chb_s2_r <= '0;
    end else if (ce) begin
      chb_s2_r <= chb_s1_r;
    end
  end

  // Power select pins.
  always_ff @(posedge clk) begin
    if (rst) begin
      psel_s1_r <= DAM_SHUTDOWN;
    end else if (ce) begin
      psel_s1_r <= {power_select_low, power_select_high};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      psel_s2_r <= DAM_SHUTDOWN;
    end else if (ce) begin
      psel_s2_r <= psel_s1_r;
    end
  end

  // Reference level comparators.
  always_ff @(posedge clk) begin
    if (rst) begin
      rlev_s1_r <= 2'h0;
    end else if (ce) begin
      rlev_s1_r <= {ref_level_high, ref_level_low};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rlev_s2_r <= 2'h0;
    end else if (ce) begin
      rlev_s2_r <= rlev_s1_r;
    end
  end

  // Converter clock edges, seen after synchronisation.
  wire cclk_rise = cclk_s2_r && !cclk_s3_r;
  wire cclk_fall = !cclk_s2_r && cclk_s3_r;

  // RULE8 power select decode
  wire dam_mode_e mode = dam_mode_e'(psel_s2_r);

  // RULE15 reference mode select
  wire dam_ref_e ref_sel = rlev_s2_r[1] ? DAM_REF_INTERNAL :
                           rlev_s2_r[0] ? DAM_REF_UNBUF    : DAM_REF_BUFFERED;
  wire ref_unbuf = (ref_sel == DAM_REF_UNBUF);

  dam_pwr_if pwr ();

  dam_power #(
    .UNBUF_WAKE_CYC (UNBUF_WAKE_CYC)
  ) u_power (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .mode      (mode),
    .ref_unbuf (ref_unbuf),
    .pwr       (pwr.ctl)
  );

  // The pipeline only moves while clocks are distributed and the converters are awake.
  wire running = pwr.clk_on && pwr.adc_on;

  // RULE6 offset binary coding
  // RULE7 full-scale end codes
  wire [SAMPLE_W-1:0] code_a = SAMPLE_W'(cha_s2_r + CODE_OFFSET);
  wire [SAMPLE_W-1:0] code_b = SAMPLE_W'(chb_s2_r + CODE_OFFSET);

  // Half-cycle delay line of code pairs, first channel in the upper byte.
  logic [2*SAMPLE_W-1:0] pipe_r [DEPTH];
  wire                   step = running && (cclk_rise || cclk_fall);

  // RULE3 simultaneous sampling
  always_ff @(posedge clk) begin
    if (rst) begin
      pipe_r[0] <= {CODE_OFFSET, CODE_OFFSET};
    end else if (ce && running && cclk_rise) begin
      pipe_r[0] <= {code_a, code_b};
    end
  end

  // RULE1 half-period stage advance
  for (genvar i = 1; i < DEPTH; i++) begin : g_stage
    always_ff @(posedge clk) begin
      if (rst) begin
        pipe_r[i] <= {CODE_OFFSET, CODE_OFFSET};
      end else if (ce && step) begin
        pipe_r[i] <= pipe_r[i-1];
      end
    end
  end

  // RULE2 per-channel latency taps
  wire [SAMPLE_W-1:0] tap_a = pipe_r[LAT_A-1][2*SAMPLE_W-1:SAMPLE_W];
  wire [SAMPLE_W-1:0] tap_b = pipe_r[LAT_B-1][SAMPLE_W-1:0];

  // Output latch and channel flag.
  logic [SAMPLE_W-1:0] bus_r;
  logic                flag_r;

  // RULE4 edge-steered output mux
  wire [SAMPLE_W-1:0] bus_nxt  = cclk_rise ? tap_a : tap_b;
  // RULE5 flag tracks clock level
  wire                flag_nxt = cclk_rise;
  // RULE18 latch held while stopped
  wire                bus_load = running && (cclk_rise || cclk_fall);

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_r <= BUS_RESET;
    end else if (ce && bus_load) begin
      bus_r <= bus_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (ce && bus_load) begin
      flag_r <= flag_nxt;
    end
  end

  // Output enables and analog controls, all registered.
  logic oe_r;
  logic adc_pwr_r;
  logic ref_pwr_r;
  logic clk_dist_r;
  logic ref_buf_r;
  logic [1:0] ref_mode_r;
  logic ready_r;

  // RULE14 normal mode drives pins
  wire oe_nxt = pwr.drive_on && (mode == DAM_NORMAL);
  // RULE16 unbuffered disables buffers
  wire ref_buf_nxt = pwr.ref_en && !ref_unbuf;

  always_ff @(posedge clk) begin
    if (rst) begin
      oe_r <= 1'b0;
    end else if (ce) begin
      oe_r <= oe_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      adc_pwr_r <= 1'b0;
    end else if (ce) begin
      adc_pwr_r <= pwr.adc_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_pwr_r <= 1'b0;
    end else if (ce) begin
      ref_pwr_r <= pwr.ref_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      clk_dist_r <= 1'b0;
    end else if (ce) begin
      clk_dist_r <= pwr.ref_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_buf_r <= 1'b0;
    end else if (ce) begin
      ref_buf_r <= ref_buf_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_mode_r <= DAM_REF_INTERNAL;
    end else if (ce) begin
      ref_mode_r <= ref_sel;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_r <= 1'b0;
    end else if (ce) begin
      ready_r <= running;
    end
  end

  // RULE13 latest word shown on enable
  // RULE19 bit 7 is the most significant
  assign sample_bus         = bus_r;
  // RULE9 outputs tri-stated unless driven
  // RULE12 idle keeps outputs off
  assign sample_bus_oe      = oe_r;
  assign channel_flag       = flag_r;
  assign channel_flag_oe    = oe_r;
  assign adc_power_en       = adc_pwr_r;
  assign reference_power_en = ref_pwr_r;
  assign clock_dist_en      = clk_dist_r;
  assign ref_buffer_en      = ref_buf_r;
  assign reference_mode     = ref_mode_r;
  assign converter_ready    = ready_r;

endmodule

/* tb/dam_checker.sv */
// Concurrent checks on the power pins, output enables and held output word.
`timescale 1ns/100ps
module dam_checker (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Power select pins
  input wire logic       power_select_low,
  input wire logic       power_select_high,
  // Output side
  input wire logic [7:0] sample_bus,
  input wire logic       sample_bus_oe,
  input wire logic       channel_flag_oe,
  // Analog section controls
  input wire logic       adc_power_en,
  input wire logic       reference_power_en,
  input wire logic       clock_dist_en,
  input wire logic       ref_buffer_en,
  input wire logic [1:0] reference_mode,
  input wire logic       converter_ready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire [1:0] pins = {power_select_low, power_select_high};

  // Eight cycles cover the pin synchronisers and the output registers.
  sequence s_held(m);
    (pins == m)[*8];
  endsequence

  sequence s_running;
    converter_ready[*3];
  endsequence

  a_shdn_all_off: assert property (s_held(2'b00) |->
    !reference_power_en && !clock_dist_en && !adc_power_en && !sample_bus_oe)
    else $error("shutdown left a section or driver on");
  a_stby_state: assert property (s_held(2'b01) |->
    reference_power_en && clock_dist_en && !adc_power_en && !sample_bus_oe)
    else $error("standby power state wrong");
  a_idle_tristate: assert property (s_held(2'b10) |-> !sample_bus_oe)
    else $error("idle drives the bus");
  a_normal_drive: assert property (s_held(2'b11) ##0 s_running |-> sample_bus_oe)
    else $error("normal mode does not drive the bus");
  a_oe_pair: assert property (sample_bus_oe == channel_flag_oe)
    else $error("bus and flag enables differ");
  a_dist_with_ref: assert property (clock_dist_en == reference_power_en)
    else $error("clock distribution differs from reference power");
  a_unbuf_nobuf: assert property ((reference_mode == 2'b10)[*2] |-> !ref_buffer_en)
    else $error("reference buffers on in unbuffered mode");
  a_buf_on: assert property ((reference_power_en && reference_mode == 2'b01)[*2]
    |-> ref_buffer_en)
    else $error("reference buffers off in buffered mode");
  a_wake_guard: assert property ($rose(sample_bus_oe) |->
    converter_ready && adc_power_en && reference_power_en)
    else $error("drivers on before the converters are awake");
  a_hold_word: assert property (!converter_ready[*2] |-> $stable(sample_bus))
    else $error("output word changed while stopped");
endmodule

bind dam_top dam_checker i_dam_checker (
  .clk               (clk),
  .rst               (rst),
  .power_select_low  (power_select_low),
  .power_select_high (power_select_high),
  .sample_bus        (sample_bus),
  .sample_bus_oe     (sample_bus_oe),
  .channel_flag_oe   (channel_flag_oe),
  .adc_power_en      (adc_power_en),
  .reference_power_en(reference_power_en),
  .clock_dist_en     (clock_dist_en),
  .ref_buffer_en     (ref_buffer_en),
  .reference_mode    (reference_mode),
  .converter_ready   (converter_ready)
);

/* tb/dam_capture.sv */
// Downstream capture logic: latches each channel word off the shared bus.
`timescale 1ns/100ps
module dam_capture (
  // Clock
  input  wire logic       clk,
  // Shared bus from the converter
  input  wire logic [7:0] sample_bus,
  input  wire logic       sample_bus_oe,
  input  wire logic       channel_flag,
  // Captured words
  output logic      [7:0] word_a,
  output logic      [7:0] word_b
);
  logic       flag_q;
  // A released bus is seen as a changing pattern, never as the last word.
  wire  [7:0] bus_seen = sample_bus_oe ? sample_bus : ~word_b;

  always @(posedge clk) begin
    flag_q <= channel_flag;
    if (channel_flag && !flag_q) begin
      word_a <= bus_seen;
    end
    if (!channel_flag && flag_q) begin
      word_b <= bus_seen;
    end
  end
endmodule

/* tb/dam_top_tb.sv */
// Self-checking bench for the converter output mux and power control.
`timescale 1ns/100ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module dam_top_tb;
  import dam_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ce = 1'b1;
  logic       conv_clk = 1'b0;
  logic       psl = 1'b0;
  logic       psh = 1'b0;
  logic       rl_hi = 1'b0;
  logic       rl_lo = 1'b1;
  logic [7:0] a = 8'h00;
  logic [7:0] b = 8'h00;
  logic [7:0] bus;
  logic [7:0] word_a;
  logic [7:0] word_b;
  logic [1:0] rmode;
  logic       oe, flag, flag_oe, adc_en, ref_en, cd_en, rb_en, ready;
  int         bad_count = 0;
  int         compares = 0;
  int         cyc = 0;

  dam_top #(.UNBUF_WAKE_CYC(4)) i_dam_top (
    .clk(clk), .rst(rst), .ce(ce), .conv_clk(conv_clk),
    .first_channel(a), .second_channel(b),
    .power_select_low(psl), .power_select_high(psh),
    .ref_level_high(rl_hi), .ref_level_low(rl_lo),
    .sample_bus(bus), .sample_bus_oe(oe), .channel_flag(flag), .channel_flag_oe(flag_oe),
    .adc_power_en(adc_en), .reference_power_en(ref_en), .clock_dist_en(cd_en),
    .ref_buffer_en(rb_en), .reference_mode(rmode), .converter_ready(ready));

  dam_capture i_dam_capture (.clk(clk), .sample_bus(bus), .sample_bus_oe(oe),
    .channel_flag(flag), .word_a(word_a), .word_b(word_b));

  always #5 clk = ~clk;

  always begin
    repeat (4) @(posedge clk);
    #1 conv_clk = ~conv_clk;
  end

  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // The ceiling is about four and a half times the longest expected run.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wait_oe(input logic want, input int lim, output int n);
    n = 0;
    while (oe !== want && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  task automatic t_power_up();
    int n;
    {psl, psh} = 2'b11;
    wait_oe(1'b1, 1000, n);
    `CHK({oe, n >= STBY_WAKE_CYC}, 2'b11)
    `CHK(rmode, 2'b10)
    `CHK(rb_en, 1'b0)
    `CHK({adc_en, ref_en, cd_en, ready}, 4'hf)
  endtask

  task automatic t_codes();
    logic [7:0] tab [6] = '{8'h7f, 8'h80, 8'h01, 8'hff, 8'h7e, 8'h00};
    for (int i = 0; i < 6; i++) begin
      a = tab[i];
      b = tab[5 - i];
      tick(64);
      `CHK(word_a, tab[i] + 8'h80)
      `CHK(word_b, tab[5 - i] + 8'h80)
    end
  endtask

  task automatic t_latency();
    @(negedge conv_clk);
    tick(1);
    a = 8'h11;
    b = 8'h22;
    repeat (5) @(posedge conv_clk);
    tick(6);
    `CHK(word_a, 8'h80)
    @(posedge conv_clk);
    tick(6);
    `CHK(word_a, 8'h91)
    `CHK(word_b, 8'hff)
    tick(6);
    `CHK(word_b, 8'ha2)
  endtask

  task automatic t_idle();
    int n;
    {psl, psh} = 2'b10;
    wait_oe(1'b0, 10, n);
    `CHK({oe, ready, adc_en}, 3'b011)
    a = 8'h35;
    b = 8'h35;
    tick(100);
    {psl, psh} = 2'b11;
    wait_oe(1'b1, 8, n);
    `CHK(oe, 1'b1)
    `CHK(bus, 8'hb5)
    // With the enable low, new inputs and clock edges must leave the pins untouched.
    ce = 1'b0;
    a = 8'h66;
    b = 8'h66;
    tick(40);
    `CHK({bus, oe}, 9'h16b)
    ce = 1'b1;
  endtask

  task automatic t_standby();
    int n;
    {psl, psh} = 2'b01;
    tick(8);
    `CHK({adc_en, ref_en, cd_en, oe}, 4'b0110)
    a = 8'h44;
    tick(40);
    `CHK(bus, 8'hb5)
    {psl, psh} = 2'b11;
    wait_oe(1'b1, 700, n);
    `CHK({oe, n >= STBY_WAKE_CYC}, 2'b11)
  endtask

  task automatic t_shutdown();
    int n;
    {psl, psh} = 2'b00;
    tick(8);
    `CHK({adc_en, ref_en, cd_en, oe, flag_oe}, 5'h00)
    {rl_hi, rl_lo} = 2'b00;
    {psl, psh} = 2'b01;
    tick(8);
    `CHK({rmode, rb_en}, 3'b011)
    rl_hi = 1'b1;
    {psl, psh} = 2'b11;
    wait_oe(1'b1, 3000, n);
    `CHK(rmode, 2'b00)
    `CHK({oe, n >= SHDN_WAKE_CYC}, 2'b11)
  endtask

  initial begin
    tick(12);
    rst = 1'b0;
    tick(4);
    `CHK({bus, oe, flag}, 10'h200)
    t_power_up();
    t_codes();
    t_latency();
    t_idle();
    t_standby();
    t_shutdown();
    summarize();
  end
endmodule
